// ===== adc_chain_sequencer_trigger_tb_top.sv
/*
 * Self-checking bench of the chain sequencer: pre-emption, aborts, triggers, DMA, interrupt.
 * Assumes the register offsets of the package and the register bus timing of the design.
 */
`timescale 1ns/1ps
module adc_chain_sequencer_trigger_tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, dma_ack, conv_busy, irq, dma_req, trg_ack, go, pend, pb;
  logic [11:0] s_axi_awaddr, s_axi_araddr, adc_result;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, timer_evt, rr;
  logic [6:0]  conv_ch, pc;
  logic [7:0]  acks;
  logic [6:0]  seq[$];
  int          err_total, total_checks;

  adccs_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .adc_result, .timer_evt, .dma_ack, .conv_busy, .conv_ch, .irq, .dma_req,
    .trg_ack);
  adccs_xtrig_model xtrig (.aclk, .aresetn, .go, .trg_ack, .timer_evt, .pend, .acks);

  always #25 aclk = ~aclk;
  // A pre-empted channel drops busy for one cycle, yet a change of channel also counts as a start.
  always @(posedge aclk) begin
    if (conv_busy === 1'b1 && (pb !== 1'b1 || conv_ch !== pc)) seq.push_back(conv_ch);
    pb <= conv_busy;
    pc <= conv_ch;
  end

  task automatic results;
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo;
    err_total++;
    results();
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rr = s_axi_bresp;
    if (n == 50) tmo();
  endtask
  task automatic axr(input logic [11:0] a);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    if (n == 50) tmo();
  endtask
  task automatic wait_ch(input logic [6:0] c);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (conv_busy === 1'b1 && conv_ch === c) break;
    end
    if (n == 400) tmo();
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 300; n++) begin
      axr(adccs_pkg::OFS_MST);
      if (rd[3:0] === 4'h0) break;
    end
    if (n == 300) tmo();
    repeat (3) @(posedge aclk);
    chk("idle_busy", 32'(conv_busy), 32'h0);
  endtask
  task automatic chk_seq(input logic [6:0] ex[$]);
    int i;
    chk("seq_len", 32'(seq.size()), 32'(ex.size()));
    for (i = 0; i < ex.size() && i < seq.size(); i++)
      chk("seq_ch", 32'(seq[i]), 32'(ex[i]));
  endtask

  task automatic t_inject;
    axw(adccs_pkg::OFS_IMSK, 32'h3);
    axw(adccs_pkg::OFS_NSEL, 32'hf);
    axw(adccs_pkg::OFS_ISEL, 32'h20);
    seq.delete();
    axw(adccs_pkg::OFS_MCFG, 32'h1);
    wait_ch(7'h01);
    axw(adccs_pkg::OFS_MCFG, 32'h2);
    wait_ch(7'h05);
    axw(adccs_pkg::OFS_MCFG, 32'h4);
    axw(adccs_pkg::OFS_NSEL, 32'h7);
    wait_idle();
    chk_seq({7'h00, 7'h01, 7'h05, 7'h01, 7'h02});
    chk("irq_set", 32'(irq), 32'h1);
    axr(adccs_pkg::OFS_DONE);
    chk("done", rd, 32'h7);
    axr(adccs_pkg::OFS_IST);
    chk("ist", rd, 32'h3);
    @(posedge aclk);
    chk("irq_clr", 32'(irq), 32'h0);
    axw(adccs_pkg::OFS_DONE, 32'hffff_ffff);
  endtask
  task automatic t_chain_abort;
    axw(adccs_pkg::OFS_NSEL, 32'h3);
    axw(adccs_pkg::OFS_ISEL, 32'h30);
    seq.delete();
    axw(adccs_pkg::OFS_MCFG, 32'h1);
    wait_ch(7'h00);
    axw(adccs_pkg::OFS_MCFG, 32'h2);
    wait_ch(7'h04);
    axw(adccs_pkg::OFS_MCFG, 32'h8);
    wait_idle();
    chk_seq({7'h00, 7'h04, 7'h00, 7'h01});
    axr(adccs_pkg::OFS_MCFG);
    chk("abort_bits", rd & 32'hc, 32'h0);
    axr(adccs_pkg::OFS_IST);
    chk("ist_abort", rd, 32'h3);
    axr(adccs_pkg::OFS_DONE);
    chk("done_abort", rd, 32'h3);
  endtask
  task automatic t_trigger;
    logic [7:0] cf[2];
    int i, n;
    cf = '{8'h49, 8'hff};
    for (i = 0; i < 2; i++) begin
      axw(adccs_pkg::OFS_TCFG, 32'(cf[i]));
      seq.delete();
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      for (n = 0; n < 200; n++) begin
        @(posedge aclk);
        if (pend === 1'b0) break;
      end
      if (n == 200) tmo();
      wait_idle();
      chk_seq({{1'b0, cf[i][5:0]}});
      chk("acks", 32'(acks), 32'(i + 1));
      axr(adccs_pkg::OFS_IST);
    end
  endtask
  task automatic t_dma;
    axw(adccs_pkg::OFS_DMAE, 32'h3);
    chk("bresp_ok", 32'(rr), 32'(adccs_pkg::RESP_OK));
    axw(adccs_pkg::OFS_DCHE, 32'h8);
    axw(adccs_pkg::OFS_NSEL, 32'h8);
    axw(adccs_pkg::OFS_MCFG, 32'h1);
    wait_idle();
    chk("dma_set", 32'(dma_req), 32'h1);
    dma_ack <= 1'b1;
    @(posedge aclk);
    dma_ack <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("dma_hold", 32'(dma_req), 32'h1);
    axr(adccs_pkg::OFS_DATA + 12'h00c);
    chk("data3", rd, 32'h5a3);
    repeat (2) @(posedge aclk);
    chk("dma_read", 32'(dma_req), 32'h0);
    axw(adccs_pkg::OFS_DMAE, 32'h1);
    axw(adccs_pkg::OFS_MCFG, 32'h1);
    wait_idle();
    chk("dma_set_ack", 32'(dma_req), 32'h1);
    dma_ack <= 1'b1;
    @(posedge aclk);
    dma_ack <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("dma_ack_clr", 32'(dma_req), 32'h0);
    axw(12'h0fc, 32'h0000_0000);
    chk("unmapped_w", 32'(rr), 32'(adccs_pkg::RESP_ERR));
    axr(12'h0fc);
    chk("unmapped", 32'(rr), 32'(adccs_pkg::RESP_ERR));
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, dma_ack, go} = 5'h00;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    adc_result = 12'h5a3;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("irq_rst", 32'(irq), 32'h0);
    chk("dma_rst", 32'(dma_req), 32'h0);
    axr(adccs_pkg::OFS_IMSK);
    chk("imsk_rst", rd, 32'(adccs_pkg::IMSK_RST));
    t_inject();
    t_chain_abort();
    t_trigger();
    t_dma();
    results();
  end
endmodule

// ===== adccs_pkg.sv
/*
 * Constants, register map and carrier types of the converter chain sequencer.
 * Assumes a single 20 MHz clock domain and an AXI4-Lite master with 12 address bits.
 */
// Contract
// RL1: Injected chain pre-empts, aborted normal channel reconverted.
// RL2: Injected channel abort still restores normal chain.
// RL3: Done flag only for actually converted channels.
// RL4: Every chain end raises end-of-chain event.
// RL5: Clear-on-read keeps DMA request until read.
// RL6: Chain abort sets injected done, self-clears.
// RL7: Aborts after chain start end channel/chain.
// RL8: Every trigger conversion acknowledged, even aborted.
// RL9: Software issues aborts only while chain runs.
// RL10: Normal running bit low means converter idle; an injected chain still converts with it low.
// RL11: Normal select bits gate each chain step.
// RL12: Trigger channel index six bits, channels 0-63.
// RL13: Trigger latches configured channel, option ignored.
// RL14: Result write with DMA enabled requests DMA.
package adccs_pkg;

  localparam int AW = 12;

  localparam logic [11:0] OFS_MCFG = 12'h000;
  localparam logic [11:0] OFS_MST  = 12'h004;
  localparam logic [11:0] OFS_IST  = 12'h008;
  localparam logic [11:0] OFS_IMSK = 12'h00c;
  localparam logic [11:0] OFS_DMAE = 12'h010;
  localparam logic [11:0] OFS_NSEL = 12'h020;
  localparam logic [11:0] OFS_ISEL = 12'h030;
  localparam logic [11:0] OFS_DCHE = 12'h040;
  localparam logic [11:0] OFS_DONE = 12'h050;
  localparam logic [11:0] OFS_TCFG = 12'h060;
  localparam logic [11:0] OFS_DATA = 12'h100;

  localparam int MC_NORMAL_CHAIN_RUNNING = 0;
  localparam int MC_ISTART = 1;
  localparam int MC_CHAB   = 2;
  localparam int MC_CHNAB  = 3;

  localparam int ST_NRUN   = 0;
  localparam int ST_IRUN   = 1;
  localparam int ST_BUSY   = 2;
  localparam int ST_TBUSY  = 3;
  localparam int ST_CH_LSB = 8;

  localparam int IS_EOC  = 0;
  localparam int IS_INJD = 1;

  localparam logic [1:0] IMSK_RST = 2'h0;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  localparam int CONV_TIME_NS  = 1000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {
    S_IDLE = 1'b0,
    S_CONV = 1'b1
  } adccs_st_type;

  typedef struct packed {
    logic       clr_opt;
    logic       en;
    logic [5:0] ch;
  } adccs_tcfg_type;

  typedef struct packed {
    logic clr_on_rd;
    logic en;
  } adccs_dmae_type;

  localparam adccs_tcfg_type TCFG_RST = 8'h00;
  localparam adccs_dmae_type DMAE_RST = 2'h0;

endpackage

// ===== adccs_top.sv
/*
 * Chain sequencer of the converter with its trigger latch, register slave, interrupt and DMA.
 * Assumes the analog result is valid on adc_result when a conversion ends and dma_ack is
 * a same-clock pulse from the DMA controller; timer events are asynchronous levels.
 */
`timescale 1ns/1ps
module adccs_top #(
  parameter int NCH  = 96,
  parameter int NEVT = 2,
  parameter int RW   = 12
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [11:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [11:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [RW-1:0]   adc_result,
  input  wire logic [NEVT-1:0] timer_evt,
  input  wire logic            dma_ack,
  output logic                 conv_busy,
  output logic [6:0]           conv_ch,
  output logic                 irq,
  output logic                 dma_req,
  output logic                 trg_ack
);

  localparam int NW = NCH / 32;
  localparam int CW = $clog2(adccs_pkg::CONV_CYC);

  logic                     aw_h_ff, w_h_ff, awready_ff, wready_ff, bvalid_ff;
  logic                     arready_ff, rvalid_ff;
  logic [1:0]               bresp_ff, rresp_ff;
  logic [31:0]              rdata_ff, wd_ff, wm, rd_d;
  logic [11:0]              wa_ff;
  logic [3:0]               ws_ff;
  logic                     wr_fire, ar_take, rd_ok, rd_ist, rd_dat, in_data;
  logic [6:0]               di;
  logic [NCH-1:0]           nsel_ff, isel_ff, dche_ff, done_ff, inj_mask_ff, onehot, done_clr;
  adccs_pkg::adccs_tcfg_type tcfg_ff [NEVT];
  adccs_pkg::adccs_dmae_type dmae_ff;
  logic [1:0]               imsk_ff, ist_ff, nxt_ist;
  logic [RW-1:0]            data_mem [NCH];
  adccs_pkg::adccs_st_type  st_ff;
  logic                     nrm_act_ff, inj_act_ff, inj_trg_ff, cur_inj_ff;
  logic [6:0]               nrm_ptr_ff, inj_ptr_ff, cur_ch_ff, done_ch_ff;
  logic [CW-1:0]            cnt_ff;
  logic [RW-1:0]            res_ff;
  logic                     eoc_p_ff, injd_p_ff, done_p_ff, trg_ack_ff;
  logic                     chab_ff, chnab_ff, irq_ff, dma_req_ff;
  logic [7:0]               nrm_nx, inj_nx;
  logic                     busy, chain_run, inj_req_sw, inj_req, inj_take, preempt;
  logic                     start_nrm, use_chab, use_chnab, dma_set, mcfg_wr;
  logic [NEVT-1:0]          ev_s1_ff, ev_s2_ff, ev_s3_ff;
  logic                     trg_busy_ff, trg_sent_ff, evt_hit, trg_take;
  logic [5:0]               trg_ch_ff, evt_ch;

  function automatic logic [7:0] find_from(input logic [NCH-1:0] m, input logic [6:0] s);
    logic [7:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i] && 7'(i) >= s) begin
        r = {1'b1, 7'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic wr_at(input logic [11:0] o);
    return wr_fire && wa_ff == o;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~wm) | (wd_ff & wm);
  endfunction

  // AXI4-Lite slave: address and data are held independently, the write fires once both are in.
  assign wr_fire = aw_h_ff & w_h_ff & ~bvalid_ff;
  assign wm      = {{8{ws_ff[3]}}, {8{ws_ff[2]}}, {8{ws_ff[1]}}, {8{ws_ff[0]}}};
  assign ar_take = s_axi_arvalid & arready_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h_ff    <= 1'b0;
      w_h_ff     <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= adccs_pkg::RESP_OK;
      wa_ff      <= 12'h000;
      wd_ff      <= 32'h0000_0000;
      ws_ff      <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_h_ff    <= 1'b1;
        awready_ff <= 1'b0;
        wa_ff      <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_h_ff    <= 1'b0;
        awready_ff <= 1'b1;
      end else begin
        awready_ff <= ~aw_h_ff;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_h_ff    <= 1'b1;
        wready_ff <= 1'b0;
        wd_ff     <= s_axi_wdata;
        ws_ff     <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_h_ff    <= 1'b0;
        wready_ff <= 1'b1;
      end else begin
        wready_ff <= ~w_h_ff;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wa_ff[1:0] == 2'h0 && (wa_ff < 12'h014 || (wa_ff >= adccs_pkg::OFS_NSEL
                     && wa_ff < adccs_pkg::OFS_TCFG + 12'(4 * NEVT)) || (wa_ff >=
                     adccs_pkg::OFS_DATA && wa_ff < adccs_pkg::OFS_DATA + 12'(4 * NCH))))
                     ? adccs_pkg::RESP_OK : adccs_pkg::RESP_ERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign in_data = s_axi_araddr >= adccs_pkg::OFS_DATA
                   && s_axi_araddr < adccs_pkg::OFS_DATA + 12'(4 * NCH);
  assign di      = 7'((s_axi_araddr - adccs_pkg::OFS_DATA) >> 2);
  assign rd_ist  = ar_take && s_axi_araddr == adccs_pkg::OFS_IST;
  assign rd_dat  = ar_take && in_data && s_axi_araddr[1:0] == 2'h0;

  always_comb begin
    rd_d  = 32'h0000_0000;
    rd_ok = s_axi_araddr[1:0] == 2'h0;
    case (s_axi_araddr)
      adccs_pkg::OFS_MCFG: rd_d = {28'h0, chnab_ff, chab_ff, 2'h0};
      adccs_pkg::OFS_MST: begin
        rd_d[adccs_pkg::ST_NRUN]  = nrm_act_ff; // [RL10]
        rd_d[adccs_pkg::ST_IRUN]  = inj_act_ff;
        rd_d[adccs_pkg::ST_BUSY]  = busy;
        rd_d[adccs_pkg::ST_TBUSY] = trg_busy_ff;
        rd_d[adccs_pkg::ST_CH_LSB +: 7] = cur_ch_ff;
      end
      adccs_pkg::OFS_IST:  rd_d = {30'h0, ist_ff};
      adccs_pkg::OFS_IMSK: rd_d = {30'h0, imsk_ff};
      adccs_pkg::OFS_DMAE: rd_d = {30'h0, dmae_ff};
      default: begin
        rd_ok = rd_ok && in_data;
        for (int k = 0; k < NW; k++) begin
          if (s_axi_araddr == adccs_pkg::OFS_NSEL + 12'(4 * k)) rd_d = nsel_ff[32*k +: 32];
          if (s_axi_araddr == adccs_pkg::OFS_ISEL + 12'(4 * k)) rd_d = isel_ff[32*k +: 32];
          if (s_axi_araddr == adccs_pkg::OFS_DCHE + 12'(4 * k)) rd_d = dche_ff[32*k +: 32];
          if (s_axi_araddr == adccs_pkg::OFS_DONE + 12'(4 * k)) rd_d = done_ff[32*k +: 32];
        end
        if (s_axi_araddr[11:4] >= adccs_pkg::OFS_NSEL[11:4] && s_axi_araddr[11:4]
            <= adccs_pkg::OFS_DONE[11:4] && s_axi_araddr[3:2] < 2'(NW)) begin
          rd_ok = s_axi_araddr[1:0] == 2'h0;
        end
        for (int e = 0; e < NEVT; e++) begin
          if (s_axi_araddr == adccs_pkg::OFS_TCFG + 12'(4 * e)) begin
            rd_d  = {24'h0, tcfg_ff[e]};
            rd_ok = 1'b1;
          end
        end
        if (in_data) rd_d = 32'(data_mem[di]);
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= adccs_pkg::RESP_OK;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_ok ? rd_d : 32'h0000_0000;
      rresp_ff   <= rd_ok ? adccs_pkg::RESP_OK : adccs_pkg::RESP_ERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end else begin
      arready_ff <= ~rvalid_ff;
    end
  end

  // Configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nsel_ff <= '0;
      isel_ff <= '0;
      dche_ff <= '0;
      imsk_ff <= adccs_pkg::IMSK_RST;
      dmae_ff <= adccs_pkg::DMAE_RST;
      for (int e = 0; e < NEVT; e++) tcfg_ff[e] <= adccs_pkg::TCFG_RST;
    end else begin
      if (wr_at(adccs_pkg::OFS_IMSK)) imsk_ff <= 2'(merge(32'(imsk_ff)));
      if (wr_at(adccs_pkg::OFS_DMAE)) dmae_ff <= 2'(merge(32'(dmae_ff)));
      for (int k = 0; k < NW; k++) begin
        if (wr_at(adccs_pkg::OFS_NSEL + 12'(4 * k)))
          nsel_ff[32*k +: 32] <= merge(nsel_ff[32*k +: 32]);
        if (wr_at(adccs_pkg::OFS_ISEL + 12'(4 * k)))
          isel_ff[32*k +: 32] <= merge(isel_ff[32*k +: 32]);
        if (wr_at(adccs_pkg::OFS_DCHE + 12'(4 * k)))
          dche_ff[32*k +: 32] <= merge(dche_ff[32*k +: 32]);
      end
      for (int e = 0; e < NEVT; e++) begin
        if (wr_at(adccs_pkg::OFS_TCFG + 12'(4 * e))) tcfg_ff[e] <= 8'(merge(32'(tcfg_ff[e])));
      end
    end
  end

  // Sequencer decisions.
  assign busy       = st_ff == adccs_pkg::S_CONV;
  assign chain_run  = nrm_act_ff | inj_act_ff;
  // A continuous assign does not wake on what a function reads, so this decode is spelt out.
  assign mcfg_wr    = wr_fire && wa_ff == adccs_pkg::OFS_MCFG && ws_ff[0];
  assign start_nrm  = mcfg_wr && wd_ff[adccs_pkg::MC_NORMAL_CHAIN_RUNNING];
  assign inj_req_sw = mcfg_wr && wd_ff[adccs_pkg::MC_ISTART];
  assign inj_req    = inj_req_sw | (trg_busy_ff & ~trg_sent_ff);
  assign inj_take   = inj_req & ~inj_act_ff;
  assign preempt    = busy & inj_take & ~cur_inj_ff;
  assign use_chnab  = busy & chnab_ff & ~preempt;
  assign use_chab   = busy & (chab_ff | chnab_ff) & ~preempt;
  assign nrm_nx     = find_from(nsel_ff, nrm_ptr_ff); // [RL11]
  assign inj_nx     = find_from(inj_mask_ff, inj_ptr_ff);

  always_comb begin
    onehot = '0;
    onehot[{1'b0, trg_ch_ff}] = 1'b1; // [RL12]
  end

  // Abort requests written while no chain runs are dropped, so they can never pre-arm.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chab_ff  <= 1'b0;
      chnab_ff <= 1'b0;
    end else begin
      chab_ff  <= chain_run & ((chab_ff & ~use_chab) | (wr_at(adccs_pkg::OFS_MCFG) // [RL7]
                  & wd_ff[adccs_pkg::MC_CHAB] & ws_ff[0]));
      chnab_ff <= chain_run & ((chnab_ff & ~use_chnab) | (wr_at(adccs_pkg::OFS_MCFG) // [RL6]
                  & wd_ff[adccs_pkg::MC_CHNAB] & ws_ff[0]));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff       <= adccs_pkg::S_IDLE;
      nrm_act_ff  <= 1'b0;
      inj_act_ff  <= 1'b0;
      inj_trg_ff  <= 1'b0;
      cur_inj_ff  <= 1'b0;
      nrm_ptr_ff  <= 7'h00;
      inj_ptr_ff  <= 7'h00;
      cur_ch_ff   <= 7'h00;
      done_ch_ff  <= 7'h00;
      inj_mask_ff <= '0;
      cnt_ff      <= '0;
      res_ff      <= '0;
      eoc_p_ff    <= 1'b0;
      injd_p_ff   <= 1'b0;
      done_p_ff   <= 1'b0;
      trg_ack_ff  <= 1'b0;
    end else begin
      eoc_p_ff   <= 1'b0;
      injd_p_ff  <= 1'b0;
      done_p_ff  <= 1'b0;
      trg_ack_ff <= 1'b0;
      if (start_nrm && !nrm_act_ff) begin
        nrm_act_ff <= 1'b1;
        nrm_ptr_ff <= 7'h00;
      end
      if (inj_take) begin
        inj_act_ff  <= 1'b1;
        inj_ptr_ff  <= 7'h00;
        inj_mask_ff <= inj_req_sw ? isel_ff : onehot;
        inj_trg_ff  <= ~inj_req_sw;
      end
      if (busy) begin
        if (preempt) begin
          st_ff <= adccs_pkg::S_IDLE; // [RL1] pointer is left unchanged, so the next search finds the aborted channel again
        end else if (chnab_ff) begin
          st_ff    <= adccs_pkg::S_IDLE;
          eoc_p_ff <= 1'b1;
          if (cur_inj_ff) begin
            inj_act_ff <= 1'b0;
            injd_p_ff  <= 1'b1; // [RL6]
            trg_ack_ff <= inj_trg_ff; // [RL8]
          end else begin
            nrm_act_ff <= 1'b0;
          end
        end else if (chab_ff) begin
          st_ff <= adccs_pkg::S_IDLE; // [RL2] [RL3] no flag; an injected abort leaves the normal chain untouched
          if (cur_inj_ff) inj_ptr_ff <= cur_ch_ff + 7'h01;
          else nrm_ptr_ff <= cur_ch_ff + 7'h01;
        end else if (cnt_ff == '0) begin
          st_ff      <= adccs_pkg::S_IDLE;
          done_p_ff  <= 1'b1; // [RL3]
          done_ch_ff <= cur_ch_ff;
          res_ff     <= adc_result;
          if (cur_inj_ff) inj_ptr_ff <= cur_ch_ff + 7'h01;
          else nrm_ptr_ff <= cur_ch_ff + 7'h01;
        end else begin
          cnt_ff <= cnt_ff - CW'(1);
        end
      end else if (inj_act_ff) begin
        if (inj_nx[7]) begin
          st_ff      <= adccs_pkg::S_CONV;
          cur_ch_ff  <= inj_nx[6:0];
          cur_inj_ff <= 1'b1;
          cnt_ff     <= CW'(adccs_pkg::CONV_CYC - 1);
        end else begin
          inj_act_ff <= 1'b0;
          eoc_p_ff   <= 1'b1; // [RL4]
          injd_p_ff  <= 1'b1;
          trg_ack_ff <= inj_trg_ff; // [RL8]
        end
      end else if (nrm_act_ff && !inj_take) begin
        if (nrm_nx[7]) begin
          st_ff      <= adccs_pkg::S_CONV; // [RL11]
          cur_ch_ff  <= nrm_nx[6:0];
          cur_inj_ff <= 1'b0;
          cnt_ff     <= CW'(adccs_pkg::CONV_CYC - 1);
        end else begin
          nrm_act_ff <= 1'b0; // [RL10]
          eoc_p_ff   <= 1'b1; // [RL4]
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (done_p_ff) data_mem[done_ch_ff] <= res_ff;
  end

  // Flags, interrupt and DMA request; a hardware set always beats a software clear.
  always_comb begin
    done_clr = '0;
    for (int k = 0; k < NW; k++) begin
      if (wr_at(adccs_pkg::OFS_DONE + 12'(4 * k))) done_clr[32*k +: 32] = wd_ff & wm;
    end
    nxt_ist = (ist_ff & ~{2{rd_ist}}) | {injd_p_ff, eoc_p_ff};
  end

  assign dma_set = done_p_ff & dmae_ff.en & dche_ff[done_ch_ff];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_ff    <= '0;
      ist_ff     <= 2'h0;
      irq_ff     <= 1'b0;
      dma_req_ff <= 1'b0;
    end else begin
      done_ff    <= (done_ff & ~done_clr) | (done_p_ff ? (NCH'(1) << done_ch_ff) : '0); // [RL3]
      ist_ff     <= nxt_ist; // [RL4]
      irq_ff     <= |(nxt_ist & imsk_ff);
      dma_req_ff <= dma_set | (dma_req_ff // [RL14]
                    & ~(dmae_ff.clr_on_rd ? rd_dat : dma_ack)); // [RL5]
    end
  end

  // Trigger latch: one request outstanding, events during the wait are not queued.
  always_comb begin
    evt_hit = 1'b0;
    evt_ch  = 6'h00;
    for (int e = NEVT - 1; e >= 0; e--) begin
      if (ev_s2_ff[e] && !ev_s3_ff[e] && tcfg_ff[e].en) begin
        evt_hit = 1'b1;
        evt_ch  = tcfg_ff[e].ch; // [RL13] option bit never selects an older channel
      end
    end
  end

  assign trg_take = evt_hit & ~trg_busy_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_s1_ff    <= '0;
      ev_s2_ff    <= '0;
      ev_s3_ff    <= '0;
      trg_busy_ff <= 1'b0;
      trg_sent_ff <= 1'b0;
      trg_ch_ff   <= 6'h00;
    end else begin
      ev_s1_ff <= timer_evt;
      ev_s2_ff <= ev_s1_ff;
      ev_s3_ff <= ev_s2_ff;
      if (trg_take) begin
        trg_busy_ff <= 1'b1;
        trg_sent_ff <= 1'b0;
        trg_ch_ff   <= evt_ch; // [RL12] [RL13]
      end else if (trg_ack_ff) begin
        trg_busy_ff <= 1'b0; // [RL8]
      end else if (inj_take && !inj_req_sw) begin
        trg_sent_ff <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign conv_busy     = st_ff;
  assign conv_ch       = cur_ch_ff;
  assign irq           = irq_ff;
  assign dma_req       = dma_req_ff;
  assign trg_ack       = trg_ack_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_preempt_keep: assert property (preempt // [RL1]
    |=> nrm_act_ff && nrm_ptr_ff == $past(nrm_ptr_ff))
    else $error("pre-empted normal channel lost");
  a_inj_abort: assert property (use_chab && !chnab_ff && cur_inj_ff // [RL2]
    |=> nrm_act_ff == $past(nrm_act_ff) && nrm_ptr_ff == $past(nrm_ptr_ff))
    else $error("injected abort disturbed normal chain");
  a_done_flag: assert property (done_p_ff |=> done_ff[$past(done_ch_ff)]) // [RL3]
    else $error("done flag not set");
  a_abort_noflag: assert property (use_chab |=> !done_p_ff) // [RL3]
    else $error("aborted channel flagged");
  a_eoc_irq: assert property (eoc_p_ff |=> ist_ff[adccs_pkg::IS_EOC]) // [RL4]
    else $error("end of chain not recorded");
  a_dma_hold: assert property (dma_req_ff && dmae_ff.clr_on_rd && !rd_dat |=> dma_req_ff) // [RL5]
    else $error("dma request dropped early");
  a_chain_abort: assert property (use_chnab && cur_inj_ff // [RL6]
    |=> injd_p_ff && !inj_act_ff ##1 ist_ff[adccs_pkg::IS_INJD])
    else $error("chain abort did not finish injected chain");
  a_abort_ends: assert property (use_chab |=> st_ff == adccs_pkg::S_IDLE) // [RL7]
    else $error("channel abort ignored");
  a_trig_ack: assert property ($rose(trg_sent_ff) |-> ##[1:40] trg_ack_ff) // [RL8]
    else $error("trigger request never acknowledged");
  a_idle_quiet: assert property (!chain_run |-> st_ff == adccs_pkg::S_IDLE) // [RL10]
    else $error("converting with no chain running");
  a_sel_gate: assert property (st_ff == adccs_pkg::S_IDLE && nrm_act_ff && !inj_act_ff // [RL11]
    && !inj_take && nrm_nx[7] |=> busy && nsel_ff[cur_ch_ff] || $past(wr_fire))
    else $error("unselected channel converted");
  a_trig_latch: assert property (trg_take |=> trg_ch_ff == $past(evt_ch)) // [RL13]
    else $error("wrong trigger channel latched");
  a_dma_set: assert property (dma_set |=> dma_req_ff) // [RL14]
    else $error("dma request missing");

  c_preempt:   cover property (preempt ##[1:100] done_p_ff && !cur_inj_ff);
  c_inj_abort: cover property (use_chnab && cur_inj_ff && nrm_act_ff);
  c_dma_read:  cover property (dma_req_ff && dmae_ff.clr_on_rd ##[1:50] rd_dat);
  c_trig:      cover property (trg_take ##[1:60] trg_ack_ff);

endmodule

// ===== adccs_xtrig_model.sv
/*
 * Behavioural model of the cross-trigger unit that faces the sequencer's trigger side.
 * Assumes the sequencer answers every taken timer event with a one-cycle trg_ack pulse.
 */
`timescale 1ns/1ps
module adccs_xtrig_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic       trg_ack,
  output logic [1:0]      timer_evt,
  output logic            pend,
  output logic [7:0]      acks
);
  // The event level is held until the answer, so a slow converter never loses a request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_evt <= 2'h0;
      pend      <= 1'b0;
      acks      <= 8'h00;
    end else if (pend) begin
      if (trg_ack) begin
        timer_evt <= 2'h0;
        pend      <= 1'b0;
        acks      <= acks + 8'h01;
      end
    end else if (go) begin
      timer_evt <= 2'h1;
      pend      <= 1'b1;
    end
  end
endmodule
